// >>> hdl/ocs_pkg.sv
package ocs_pkg;

    // clock and rate limits
    localparam int unsigned REF_CLK_MHZ = 100;
    localparam int unsigned FCY_MAX_MHZ = 40;

    // register port
    localparam int unsigned ADDR_W       = 4;
    localparam int unsigned DATA_W       = 16;
    localparam logic [3:0]  ADDR_CLK_DIV = 4'h0;
    localparam logic [3:0]  ADDR_PLL_FB  = 4'h1;
    localparam logic [3:0]  ADDR_STATUS  = 4'h2;

    // clock divisor register fields and reset
    localparam int unsigned PRE_LSB      = 0;
    localparam int unsigned PRE_W        = 5;
    localparam int unsigned POST_LSB     = 6;
    localparam int unsigned POST_W       = 2;
    localparam int unsigned FRC_DIV_LSB  = 8;
    localparam int unsigned FRC_DIV_W    = 3;
    localparam logic [15:0] CLK_DIV_RST  = 16'h0000;
    localparam logic [15:0] CLK_DIV_MASK = 16'h07DF;

    // feedback register field and reset
    localparam int unsigned FB_W         = 9;
    localparam logic [8:0]  PLL_FB_RST   = 9'h01E;

    // status register fields
    localparam int unsigned ST_MODE_LSB  = 0;
    localparam int unsigned ST_SRC_LSB   = 4;
    localparam int unsigned ST_PLL_BIT   = 8;
    localparam int unsigned ST_CAP_BIT   = 9;
    localparam int unsigned ST_SEL_LSB   = 10;
    localparam int unsigned ST_PMD_LSB   = 13;

    // divider arithmetic
    localparam int unsigned CNT_W        = 10;
    localparam logic [9:0]  PRE_OFFSET   = 10'h002;
    localparam logic [9:0]  FB_OFFSET    = 10'h002;
    localparam logic [9:0]  FRC_DIV16    = 10'h010;
    localparam logic [9:0]  POST_DIV2    = 10'h002;
    localparam logic [9:0]  POST_DIV4    = 10'h004;
    localparam logic [9:0]  POST_DIV8    = 10'h008;

    // initial oscillator select codes
    localparam logic [2:0]  OSC_FRC       = 3'h0;
    localparam logic [2:0]  OSC_FRC_PLL   = 3'h1;
    localparam logic [2:0]  OSC_PRI       = 3'h2;
    localparam logic [2:0]  OSC_PRI_PLL   = 3'h3;
    localparam logic [2:0]  OSC_SEC       = 3'h4;
    localparam logic [2:0]  OSC_LOW_POWER_INTERNAL_RC      = 3'h5;
    localparam logic [2:0]  OSC_FRC_DIV16 = 3'h6;
    localparam logic [2:0]  OSC_FRC_DIVN  = 3'h7;

    // primary oscillator mode codes
    localparam logic [1:0]  PRI_EC  = 2'h0;
    localparam logic [1:0]  PRI_XT  = 2'h1;
    localparam logic [1:0]  PRI_HS  = 2'h2;
    localparam logic [1:0]  PRI_OFF = 2'h3;

    // configuration capture
    localparam int unsigned CFG_W      = 5;
    localparam logic [1:0]  CFG_SETTLE = 2'h3;

    // oscillator input indices
    localparam int unsigned N_OSC   = 5;
    localparam int unsigned IX_FRC  = 0;
    localparam int unsigned IX_PRI  = 1;
    localparam int unsigned IX_SEC  = 2;
    localparam int unsigned IX_LOW_POWER_INTERNAL_RC = 3;
    localparam int unsigned IX_VCO  = 4;

    // active oscillator source
    typedef enum logic [3:0] {
        SRC_FRC  = 4'b0001,
        SRC_PRI  = 4'b0010,
        SRC_SEC  = 4'b0100,
        SRC_LOW_POWER_INTERNAL_RC = 4'b1000
    } ocs_src_e;

    // nonvolatile oscillator configuration word
    typedef struct packed {
        logic [2:0] initial_osc_select;
        logic [1:0] primary_osc_mode_sel;
    } ocs_cfg_s;

    localparam ocs_cfg_s CFG_RST = '{initial_osc_select: 3'h0, primary_osc_mode_sel: 2'h0};

    // clock divisor register layout
    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic [2:0] fast_rc_divide_sel;
        logic [1:0] pll_postscale_sel;
        logic       rsvd_lo;
        logic [4:0] pll_prescale_sel;
    } ocs_clock_divisor_reg_s;

endpackage

// >>> hdl/ocs_edge_sync.sv
`timescale 1ns/10ps
module ocs_edge_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // levels from outside the clock domain
    input  wire logic [W-1:0] async_in,
    // synchronised level and registered rising-edge pulse
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;
    logic [W-1:0] rise_q;
    logic [W-1:0] rise_d;

    // edge found only between the second and third stages
    always_comb begin
        rise_d = sync_q & ~last_q;
    end

    // two-stage synchroniser, history stage and edge pulse
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
            rise_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= rise_d;
        end
    end

    assign level = sync_q;
    assign rise  = rise_q;

endmodule // ocs_edge_sync

// >>> hdl/ocs_clock_select.sv
`timescale 1ns/10ps
module ocs_clock_select (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    // register port
    input  wire logic [ocs_pkg::ADDR_W-1:0]   addr,
    input  wire logic [ocs_pkg::DATA_W-1:0]   wdata,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [ocs_pkg::DATA_W-1:0]   rdata,
    // nonvolatile configuration word pins
    input  wire ocs_pkg::ocs_cfg_s            osc_select_config_word,
    // oscillator and vco pins
    input  wire logic                         frc_osc,
    input  wire logic                         pri_osc,
    input  wire logic                         sec_osc,
    input  wire logic                         low_power_internal_rc_osc,
    input  wire logic                         vco_clk,
    // pll control towards the analog loop
    output logic                              pll_enable,
    output logic                              pll_ref_en,
    output logic                              pll_fb_en,
    // system and instruction clocks
    output logic                              fosc_en,
    output logic                              instruction_clock,
    output logic                              fcy_en,
    // reference for watchdog and clock monitor
    output logic                              low_power_internal_rc_ref_en
);

    // divider counter step: hold, count or wrap
    function automatic logic [9:0] cnt_next(input logic [9:0] cnt, input logic [9:0] lim,
                                            input logic tick);
        logic [9:0] r;
        r = cnt;
        if (tick) begin
            if (cnt >= lim - 10'h001) begin
                r = 10'h000;
            end else begin
                r = cnt + 10'h001;
            end
        end
        return r;
    endfunction

    // divider terminal pulse on the wrapping edge
    function automatic logic cnt_wrap(input logic [9:0] cnt, input logic [9:0] lim,
                                      input logic tick);
        return tick && (cnt >= lim - 10'h001);
    endfunction

    // effective select: a primary in off mode falls back to fast RC
    function automatic logic [2:0] eff_sel(input ocs_pkg::ocs_cfg_s c);
        logic [2:0] s;
        s = c.initial_osc_select;
        if ((s == ocs_pkg::OSC_PRI || s == ocs_pkg::OSC_PRI_PLL) &&
            c.primary_osc_mode_sel == ocs_pkg::PRI_OFF) begin
            s = ocs_pkg::OSC_FRC;
        end
        return s;
    endfunction

    // source behind each select code
    function automatic ocs_pkg::ocs_src_e sel_src(input logic [2:0] s);
        ocs_pkg::ocs_src_e r;
        r = ocs_pkg::SRC_FRC;
        case (s)
            ocs_pkg::OSC_PRI, ocs_pkg::OSC_PRI_PLL: r = ocs_pkg::SRC_PRI;
            ocs_pkg::OSC_SEC:                       r = ocs_pkg::SRC_SEC;
            ocs_pkg::OSC_LOW_POWER_INTERNAL_RC:                      r = ocs_pkg::SRC_LOW_POWER_INTERNAL_RC;
            default:                                r = ocs_pkg::SRC_FRC;
        endcase
        return r;
    endfunction

    // index 0 to 11 of the twelve clock modes
    function automatic logic [3:0] mode_index(input ocs_pkg::ocs_cfg_s c);
        logic [3:0] m;
        logic [2:0] s;
        m = 4'h0;
        s = eff_sel(c);
        case (s)
            ocs_pkg::OSC_FRC:       m = 4'h0;
            ocs_pkg::OSC_FRC_PLL:   m = 4'h1;
            ocs_pkg::OSC_PRI:       m = 4'h2 + {2'h0, c.primary_osc_mode_sel};
            ocs_pkg::OSC_PRI_PLL:   m = 4'h5 + {2'h0, c.primary_osc_mode_sel};
            ocs_pkg::OSC_SEC:       m = 4'h8;
            ocs_pkg::OSC_LOW_POWER_INTERNAL_RC:      m = 4'h9;
            ocs_pkg::OSC_FRC_DIV16: m = 4'hA;
            default:                m = 4'hB;
        endcase
        return m;
    endfunction

    // synchronised pins
    logic [ocs_pkg::N_OSC-1:0] osc_pins;
    logic [ocs_pkg::N_OSC-1:0] osc_rise;
    logic [ocs_pkg::CFG_W-1:0] cfg_level;

    assign osc_pins = {vco_clk, low_power_internal_rc_osc, sec_osc, pri_osc, frc_osc};

    ocs_edge_sync #(
        .W        (ocs_pkg::N_OSC)
    ) u_osc_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (osc_pins),
        .level    (),
        .rise     (osc_rise)
    );

    ocs_edge_sync #(
        .W        (ocs_pkg::CFG_W)
    ) u_cfg_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in (osc_select_config_word),
        .level    (cfg_level),
        .rise     ()
    );

    // state
    ocs_pkg::ocs_cfg_s    cfg_q,      cfg_d;
    logic [1:0]           cap_cnt_q,  cap_cnt_d;
    logic                 cap_done_q, cap_done_d;
    ocs_pkg::ocs_clock_divisor_reg_s clk_div_q,  clk_div_d;
    logic [8:0]           pll_fb_q,   pll_fb_d;
    logic [15:0]          rdata_q,    rdata_d;
    logic [9:0]           frc_cnt_q,  frc_cnt_d;
    logic [9:0]           pre_cnt_q,  pre_cnt_d;
    logic [9:0]           fb_cnt_q,   fb_cnt_d;
    logic [9:0]           post_cnt_q, post_cnt_d;
    logic                 pll_en_q,   pll_en_d;
    logic                 ref_en_q,   ref_en_d;
    logic                 fbk_en_q,   fbk_en_d;
    logic                 fosc_q,     fosc_d;
    logic                 icyc_q,     icyc_d;
    logic                 fcy_q,      fcy_d;
    logic                 low_power_internal_rc_q,     low_power_internal_rc_d;

    // decoded mode
    logic [2:0]        sel;
    ocs_pkg::ocs_src_e src;
    logic              pll_used;
    logic [3:0]        mode_ix;

    always_comb begin
        sel      = eff_sel(cfg_q);
        src      = sel_src(sel);
        mode_ix  = mode_index(cfg_q);
        pll_used = (sel == ocs_pkg::OSC_FRC_PLL) || (sel == ocs_pkg::OSC_PRI_PLL);
    end

    // configuration capture after reset release, once the pins are synchronised
    always_comb begin
        cfg_d      = cfg_q;
        cap_cnt_d  = cap_cnt_q;
        cap_done_d = cap_done_q;
        if (!cap_done_q) begin
            if (cap_cnt_q == ocs_pkg::CFG_SETTLE) begin
                cfg_d      = ocs_pkg::ocs_cfg_s'(cfg_level);
                cap_done_d = 1'b1;
            end else begin
                cap_cnt_d = cap_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_q      <= ocs_pkg::CFG_RST;
            cap_cnt_q  <= 2'h0;
            cap_done_q <= 1'b0;
        end else begin
            cfg_q      <= cfg_d;
            cap_cnt_q  <= cap_cnt_d;
            cap_done_q <= cap_done_d;
        end
    end

    // register writes and one-cycle-late read data
    always_comb begin
        clk_div_d = clk_div_q;
        pll_fb_d  = pll_fb_q;
        rdata_d   = 16'h0000;
        if (wr_stb) begin
            if (addr == ocs_pkg::ADDR_CLK_DIV) begin
                clk_div_d = ocs_pkg::ocs_clock_divisor_reg_s'(wdata & ocs_pkg::CLK_DIV_MASK);
            end else if (addr == ocs_pkg::ADDR_PLL_FB) begin
                pll_fb_d = wdata[ocs_pkg::FB_W-1:0];
            end
        end
        if (rd_stb) begin
            if (addr == ocs_pkg::ADDR_CLK_DIV) begin
                rdata_d = clk_div_q;
            end else if (addr == ocs_pkg::ADDR_PLL_FB) begin
                rdata_d = {7'h00, pll_fb_q};
            end else if (addr == ocs_pkg::ADDR_STATUS) begin
                rdata_d[ocs_pkg::ST_MODE_LSB +: 4] = mode_ix;
                rdata_d[ocs_pkg::ST_SRC_LSB +: 4]  = src;
                rdata_d[ocs_pkg::ST_PLL_BIT]       = pll_en_q;
                rdata_d[ocs_pkg::ST_CAP_BIT]       = cap_done_q;
                rdata_d[ocs_pkg::ST_SEL_LSB +: 3]  = cfg_q.initial_osc_select;
                rdata_d[ocs_pkg::ST_PMD_LSB +: 2]  = cfg_q.primary_osc_mode_sel;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clk_div_q <= ocs_pkg::ocs_clock_divisor_reg_s'(ocs_pkg::CLK_DIV_RST);
            pll_fb_q  <= ocs_pkg::PLL_FB_RST;
            rdata_q   <= 16'h0000;
        end else begin
            clk_div_q <= clk_div_d;
            pll_fb_q  <= pll_fb_d;
            rdata_q   <= rdata_d;
        end
    end

    // divider limits from the programmed fields, except the fixed divide-by-16 fast RC limit
    logic [9:0] frc_lim;
    logic [9:0] pre_lim;
    logic [9:0] fb_lim;
    logic [9:0] post_lim;
    logic       fin_tick;
    logic       vco_tick;
    logic       frc_wrap;
    logic       post_wrap;

    always_comb begin
        if (sel == ocs_pkg::OSC_FRC_DIV16) begin
            frc_lim = ocs_pkg::FRC_DIV16;
        end else begin
            frc_lim = 10'h002 << clk_div_q.fast_rc_divide_sel;
        end
        pre_lim = {5'h00, clk_div_q.pll_prescale_sel} + ocs_pkg::PRE_OFFSET;
        fb_lim  = {1'b0, pll_fb_q} + ocs_pkg::FB_OFFSET;
        case (clk_div_q.pll_postscale_sel)
            2'h0:    post_lim = ocs_pkg::POST_DIV2;
            2'h1:    post_lim = ocs_pkg::POST_DIV4;
            default: post_lim = ocs_pkg::POST_DIV8;
        endcase
    end

    // pll input only from the primary or fast RC oscillator
    always_comb begin
        if (src == ocs_pkg::SRC_PRI) begin
            fin_tick = pll_used && osc_rise[ocs_pkg::IX_PRI];
        end else begin
            fin_tick = pll_used && osc_rise[ocs_pkg::IX_FRC];
        end
        vco_tick  = pll_used && osc_rise[ocs_pkg::IX_VCO];
        frc_wrap  = cnt_wrap(frc_cnt_q, frc_lim, osc_rise[ocs_pkg::IX_FRC]);
        post_wrap = cnt_wrap(post_cnt_q, post_lim, vco_tick);
    end

    // dividers, source mux and instruction clock
    always_comb begin
        frc_cnt_d  = cnt_next(frc_cnt_q, frc_lim, osc_rise[ocs_pkg::IX_FRC]);
        pre_cnt_d  = pll_used ? cnt_next(pre_cnt_q, pre_lim, fin_tick) : 10'h000;
        fb_cnt_d   = pll_used ? cnt_next(fb_cnt_q, fb_lim, vco_tick) : 10'h000;
        post_cnt_d = pll_used ? cnt_next(post_cnt_q, post_lim, vco_tick) : 10'h000;
        pll_en_d   = pll_used;
        ref_en_d   = cnt_wrap(pre_cnt_q, pre_lim, fin_tick);
        fbk_en_d   = cnt_wrap(fb_cnt_q, fb_lim, vco_tick);
        case (sel)
            ocs_pkg::OSC_FRC:       fosc_d = osc_rise[ocs_pkg::IX_FRC];
            ocs_pkg::OSC_FRC_PLL:   fosc_d = post_wrap;
            ocs_pkg::OSC_PRI:       fosc_d = osc_rise[ocs_pkg::IX_PRI];
            ocs_pkg::OSC_PRI_PLL:   fosc_d = post_wrap;
            ocs_pkg::OSC_SEC:       fosc_d = osc_rise[ocs_pkg::IX_SEC];
            ocs_pkg::OSC_LOW_POWER_INTERNAL_RC:      fosc_d = osc_rise[ocs_pkg::IX_LOW_POWER_INTERNAL_RC];
            default:                fosc_d = frc_wrap;
        endcase
        icyc_d = icyc_q ^ fosc_d;
        fcy_d  = fosc_d & ~icyc_q;
        low_power_internal_rc_d = osc_rise[ocs_pkg::IX_LOW_POWER_INTERNAL_RC];
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frc_cnt_q  <= 10'h000;
            pre_cnt_q  <= 10'h000;
            fb_cnt_q   <= 10'h000;
            post_cnt_q <= 10'h000;
            pll_en_q   <= 1'b0;
            ref_en_q   <= 1'b0;
            fbk_en_q   <= 1'b0;
            fosc_q     <= 1'b0;
            icyc_q     <= 1'b0;
            fcy_q      <= 1'b0;
            low_power_internal_rc_q     <= 1'b0;
        end else begin
            frc_cnt_q  <= frc_cnt_d;
            pre_cnt_q  <= pre_cnt_d;
            fb_cnt_q   <= fb_cnt_d;
            post_cnt_q <= post_cnt_d;
            pll_en_q   <= pll_en_d;
            ref_en_q   <= ref_en_d;
            fbk_en_q   <= fbk_en_d;
            fosc_q     <= fosc_d;
            icyc_q     <= icyc_d;
            fcy_q      <= fcy_d;
            low_power_internal_rc_q     <= low_power_internal_rc_d;
        end
    end

    // outputs, all from flip-flops
    assign rdata             = rdata_q;
    assign pll_enable        = pll_en_q;
    assign pll_ref_en        = ref_en_q;
    assign pll_fb_en         = fbk_en_q;
    assign fosc_en           = fosc_q;
    assign instruction_clock = icyc_q;
    assign fcy_en            = fcy_q;
    assign low_power_internal_rc_ref_en       = low_power_internal_rc_q;

endmodule // ocs_clock_select

// >>> tb/ocs_clock_select_asserts.sv
`timescale 1ns/10ps
module ocs_clock_select_asserts (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       reset,
    // register port
    input wire logic [ocs_pkg::ADDR_W-1:0] addr,
    input wire logic                       rd_stb,
    input wire logic [ocs_pkg::DATA_W-1:0] rdata,
    // pll and clock outputs
    input wire logic                       pll_enable,
    input wire logic                       pll_fb_en,
    input wire logic                       fosc_en,
    input wire logic                       instruction_clock,
    input wire logic                       fcy_en,
    // low-power reference
    input wire logic                       low_power_internal_rc_osc,
    input wire logic                       low_power_internal_rc_ref_en
);
    // all checks sample on the one system clock
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // read data only in the slot after a read strobe
    AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
        else $error("read data not zero outside its slot");
    AST_RD_CLOCK_DIVISOR_REG: assert property (
        (rd_stb && addr == ocs_pkg::ADDR_CLK_DIV) |=> (rdata & ~ocs_pkg::CLK_DIV_MASK) == 16'h0000)
        else $error("divisor register shows unused bits");
    AST_RD_FB: assert property (
        (rd_stb && addr == ocs_pkg::ADDR_PLL_FB) |=> rdata[15:9] == 7'h00)
        else $error("feedback register shows unused bits");
    // instruction clock is the system clock halved
    AST_FCY_RISE: assert property (fcy_en |-> instruction_clock && !$past(instruction_clock))
        else $error("fcy_en without instruction clock rising");
    AST_FCY_PAIR: assert property ((fosc_en && instruction_clock) |-> fcy_en)
        else $error("instruction clock rose without fcy_en");
    AST_IC_TOGGLE: assert property (fosc_en |-> instruction_clock != $past(instruction_clock))
        else $error("instruction clock missed a toggle");
    AST_IC_HOLD: assert property (!fosc_en |-> $stable(instruction_clock))
        else $error("instruction clock moved without fosc_en");
    AST_ONE_CYCLE: assert property (fosc_en |=> !fosc_en)
        else $error("fosc_en longer than one cycle");
    // feedback divider idle outside pll modes
    AST_NO_PLL_FB: assert property (!pll_enable |-> !pll_fb_en)
        else $error("feedback pulse while pll unused");
    AST_LOW_POWER_INTERNAL_RC_REF: assert property ($rose(low_power_internal_rc_osc) |-> ##[2:5] low_power_internal_rc_ref_en)
        else $error("low-power reference pulse missing");
endmodule // ocs_clock_select_asserts

bind ocs_clock_select ocs_clock_select_asserts u_asserts (
    .ref_clk(ref_clk), .reset(reset), .addr(addr), .rd_stb(rd_stb), .rdata(rdata),
    .pll_enable(pll_enable), .pll_fb_en(pll_fb_en), .fosc_en(fosc_en),
    .instruction_clock(instruction_clock), .fcy_en(fcy_en), .low_power_internal_rc_osc(low_power_internal_rc_osc),
    .low_power_internal_rc_ref_en(low_power_internal_rc_ref_en)
);

// >>> tb/test_ocs_clock_select.sv
`timescale 1ns/10ps
module test_ocs_clock_select;
    logic              ref_clk, reset, wr_stb, rd_stb;
    logic [3:0]        addr;
    logic [15:0]       wdata, rdata;
    ocs_pkg::ocs_cfg_s cfg_word;
    logic [4:0]        osc;
    logic              pll_enable, pll_ref_en, pll_fb_en, fosc_en;
    logic              instruction_clock, fcy_en, low_power_internal_rc_ref_en;
    int                err_count, checks_done, cyc;
    int                n_fosc, n_fcy, n_ref, n_fb, n_lp;

    ocs_clock_select DUT (
        .ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .osc_select_config_word(cfg_word),
        .frc_osc(osc[ocs_pkg::IX_FRC]), .pri_osc(osc[ocs_pkg::IX_PRI]),
        .sec_osc(osc[ocs_pkg::IX_SEC]), .low_power_internal_rc_osc(osc[ocs_pkg::IX_LOW_POWER_INTERNAL_RC]),
        .vco_clk(osc[ocs_pkg::IX_VCO]), .pll_enable(pll_enable), .pll_ref_en(pll_ref_en),
        .pll_fb_en(pll_fb_en), .fosc_en(fosc_en), .instruction_clock(instruction_clock),
        .fcy_en(fcy_en), .low_power_internal_rc_ref_en(low_power_internal_rc_ref_en)
    );

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    // pulse counters and hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        n_fosc <= n_fosc + int'(fosc_en === 1'b1);
        n_fcy <= n_fcy + int'(fcy_en === 1'b1);
        n_ref <= n_ref + int'(pll_ref_en === 1'b1);
        n_fb <= n_fb + int'(pll_fb_en === 1'b1);
        n_lp <= n_lp + int'(low_power_internal_rc_ref_en === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t value got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            err_count++;
            $display("ERROR %0t pulse count got %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // read data is taken one cycle after the strobe, 1 ns after the clock edge
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
        @(posedge ref_clk);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // reset with a configuration word, then let it be captured
    task automatic boot(input logic [2:0] s, input logic [1:0] p);
        reset <= 1'b1;
        cfg_word <= '{s, p};
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    // n edges on one oscillator pin, then compare pulse counts
    task automatic run(input int ix, input int n, input int ef, input int eb, input int er,
                       input int el);
        int f0, c0, b0, r0, l0;
        logic ic0;
        ic0 = instruction_clock;
        f0 = n_fosc;
        c0 = n_fcy;
        b0 = n_fb;
        r0 = n_ref;
        l0 = n_lp;
        repeat (n) begin
            osc[ix] <= 1'b1;
            repeat (2) @(posedge ref_clk);
            osc[ix] <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (8) @(posedge ref_clk);
        chk_n(n_fosc - f0, ef);
        chk_n(n_fcy - c0, ef / 2);
        chk_n(n_fb - b0, eb);
        chk_n(n_ref - r0, er);
        chk_n(n_lp - l0, el);
        chk({15'h0000, instruction_clock}, {15'h0000, ic0 ^ ef[0]});
    endtask

    // status word expected for a captured configuration
    function automatic logic [15:0] exp_st(input logic [2:0] s, input logic [1:0] p);
        logic [3:0] mode;
        logic [3:0] src;
        logic       pll;
        logic       off;
        // a primary select with the primary oscillator off falls back to fast RC
        off = (s == 3'h2 || s == 3'h3) && p == 2'h3;
        mode = (s == 3'h2) ? 4'h2 + p : (s == 3'h3) ? 4'h5 + p : (s > 3'h3) ? 4'h4 + s : {1'b0, s};
        mode = off ? 4'h0 : mode;
        src = (s == 3'h2 || s == 3'h3) ? 4'h2 : (s == 3'h4) ? 4'h4 : (s == 3'h5) ? 4'h8 : 4'h1;
        src = off ? 4'h1 : src;
        pll = !off && ((s == 3'h1) || (s == 3'h3));
        return {1'b0, p, s, 1'b1, pll, src, mode};
    endfunction

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [15:0] est;
        ref_clk = 1'b0;
        reset = 1'b1;
        {wr_stb, rd_stb, addr, wdata, cfg_word, osc} = '0;
        {err_count, checks_done, cyc, n_fosc, n_fcy, n_ref, n_fb, n_lp} = '0;
        for (int s = 0; s < 8; s++) begin
            for (int p = 0; p < 4; p++) begin
                boot(3'(s), 2'(p));
                est = exp_st(3'(s), 2'(p));
                rdchk(ocs_pkg::ADDR_STATUS, est);
                chk({15'h0000, pll_enable}, {15'h0000, est[8]});
            end
        end
        boot(3'h0, 2'h0);
        rdchk(ocs_pkg::ADDR_CLK_DIV, 16'h0000);
        rdchk(ocs_pkg::ADDR_PLL_FB, 16'h001E);
        wr(ocs_pkg::ADDR_CLK_DIV, 16'hFFFF);
        rdchk(ocs_pkg::ADDR_CLK_DIV, 16'h07DF);
        wr(ocs_pkg::ADDR_PLL_FB, 16'hFFFF);
        rdchk(ocs_pkg::ADDR_PLL_FB, 16'h01FF);
        wr(4'h3, 16'hFFFF);
        rdchk(4'h3, 16'h0000);
        run(ocs_pkg::IX_FRC, 8, 8, 0, 0, 0);
        run(ocs_pkg::IX_VCO, 8, 0, 0, 0, 0);
        run(ocs_pkg::IX_LOW_POWER_INTERNAL_RC, 4, 0, 0, 0, 4);
        boot(3'h6, 2'h0);
        run(ocs_pkg::IX_FRC, 32, 2, 0, 0, 0);
        boot(3'h7, 2'h0);
        wr(ocs_pkg::ADDR_CLK_DIV, 16'h0100);
        run(ocs_pkg::IX_FRC, 16, 4, 0, 0, 0);
        wr(ocs_pkg::ADDR_CLK_DIV, 16'h0700);
        run(ocs_pkg::IX_FRC, 512, 2, 0, 0, 0);
        boot(3'h1, 2'h0);
        wr(ocs_pkg::ADDR_PLL_FB, 16'h001E);
        run(ocs_pkg::IX_FRC, 4, 0, 0, 2, 0);
        for (int k = 0; k < 4; k++) begin
            wr(ocs_pkg::ADDR_CLK_DIV, {8'h00, 2'(k), 6'h00});
            run(ocs_pkg::IX_VCO, 64, 64 / (k == 0 ? 2 : k == 1 ? 4 : 8), 2, 0, 0);
        end
        boot(3'h3, 2'h1);
        run(ocs_pkg::IX_PRI, 4, 0, 0, 2, 0);
        run(ocs_pkg::IX_FRC, 4, 0, 0, 0, 0);
        // widest prescale only behind a fast high-speed crystal
        boot(3'h3, 2'h2);
        wr(ocs_pkg::ADDR_CLK_DIV, 16'h001F);
        run(ocs_pkg::IX_PRI, 33, 0, 0, 1, 0);
        boot(3'h2, 2'h1);
        run(ocs_pkg::IX_PRI, 4, 4, 0, 0, 0);
        boot(3'h4, 2'h0);
        run(ocs_pkg::IX_SEC, 4, 4, 0, 0, 0);
        boot(3'h5, 2'h0);
        run(ocs_pkg::IX_LOW_POWER_INTERNAL_RC, 4, 4, 0, 0, 4);
        close_out();
    end
endmodule // test_ocs_clock_select
